// *** include/pwi_defs.vh ***
`ifndef PWI_DEFS_VH
`define PWI_DEFS_VH
`define PWI_ADDR_POWER_OVERRIDE 8'h0e
`define PWI_ADDR_CONVERTER_POWER 8'h0f
`define PWI_ADDR_TIMER_PENDING 8'h12
`define PWI_ADDR_ALARM_PENDING 8'h13
`define PWI_ADDR_TIMER_ENABLE 8'h15
`define PWI_ADDR_ALARM_ENABLE 8'h16
`define PWI_RST_POWER_OVERRIDE 8'h10
`define PWI_RST_CONVERTER_POWER 8'h00
`define PWI_RST_PENDING 8'h00
`define PWI_RST_ENABLE 8'h00
`define PWI_MASK_POWER_OVERRIDE 8'h3b
`define PWI_MASK_CONVERTER_POWER 8'h3f
`define PWI_BIT_METER_ON 5
`define PWI_BIT_BATT_OFF 4
`define PWI_BIT_MON_OFF 3
`define PWI_BIT_BIAS_OFF 1
`define PWI_BIT_IFACE_OFF 0
`define PWI_BIT_ADC_SEL 5
`define PWI_BIT_ADC_PWR 4
`define PWI_BIT_DAC_SEL 3
`define PWI_BIT_DAC_PWR 2
`define PWI_BIT_GM_SEL 1
`define PWI_BIT_GM_PWR 0
`endif

// *** rtl/pwi_pending.v ***
`timescale 1ns/1ps
`include "pwi_defs.vh"
// eight sticky pending flags, write-one-to-clear, set wins
module pwi_pending (
	// clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	// events and software clear
	input wire [7:0] event_i,
	input wire [7:0] clear_i,
	// flags
	output reg [7:0] pending_o
);
	genvar g;

	////////////////////////////////////////////////////////////////
	// one flip-flop per flag
	generate
		for (g = 0; g < 8; g = g + 1) begin : flag
			always @(posedge mclk_i) begin
				if (!rst_b_i)
					pending_o[g] <= 1'b0;
				else if (event_i[g])
					pending_o[g] <= 1'b1;
				else if (clear_i[g])
					pending_o[g] <= 1'b0;
			end
		end
	endgenerate
endmodule // pwi_pending

// *** rtl/pwi_power_irq.v ***
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "pwi_defs.vh"
// power override and interrupt pending register bank
module pwi_power_irq #(
	parameter HAS_BATT_CONV = 1 // 0 selects the variant without battery converter
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	// register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// event pulses and levels from the analog side (asynchronous)
	input wire [7:0] timer_evt_i,
	input wire [5:0] power_alarm_i,
	input wire hook_i,
	input wire ring_trip_i,
	// power controls
	output reg meter_dac_on_o,
	output reg battery_conv_off_o,
	output reg monitor_conv_off_o,
	output reg line_bias_off_o,
	output reg line_iface_off_o,
	output reg adc_manual_o,
	output reg adc_on_o,
	output reg dac_manual_o,
	output reg dac_on_o,
	output reg transamp_manual_o,
	output reg transamp_on_o,
	// masked pending summaries
	output reg [7:0] timer_irq_o,
	output reg [7:0] alarm_irq_o
);
	reg [7:0] power_override_ctrl;
	reg [7:0] converter_power_ctrl;
	reg [7:0] timer_irq_enable;
	reg [7:0] alarm_irq_enable;
	reg hook_prev;
	reg alarm_prev_valid;
	reg [7:0] alarm_prev;
	reg [7:0] timer_prev;
	reg [7:0] next_rdata;
	wire [7:0] timer_sync;
	wire [7:0] alarm_sync;
	wire [7:0] timer_irq_pending;
	wire [7:0] alarm_line_irq_pending;
	wire [7:0] timer_evt;
	wire [7:0] alarm_evt;
	wire [7:0] timer_clr;
	wire [7:0] alarm_clr;
	wire [7:0] po_read;
	wire meter_dac_force_on;
	wire battery_conv_force_off;
	wire monitor_conv_force_off;
	wire line_bias_force_off;
	wire line_iface_force_off;

	////////////////////////////////////////////////////////////////
	// register map, every register eight bits wide
	//   0x0e power override, reset 0x10
	//     bit 7..6 reserved, read zero, writes dropped
	//     bit 5 meter dac forced on
	//     bit 4 battery converter forced off
	//     bit 3 monitor converter forced off
	//     bit 2 reserved, read zero, writes dropped
	//     bit 1 line bias forced off
	//     bit 0 line interface forced off
	//   0x0f converter power, reset 0x00
	//     bit 7..6 reserved, read zero, writes dropped
	//     bit 5 adc manual select
	//     bit 4 adc manual power
	//     bit 3 dac manual select
	//     bit 2 dac manual power
	//     bit 1 transamp manual select
	//     bit 0 transamp manual power
	//   0x12 timer pending, write one to clear, reset 0x00
	//     bit 7 meter idle timer expired
	//     bit 6 meter active timer expired
	//     bit 5 ring idle timer expired
	//     bit 4 ring active timer expired
	//     bit 3 oscillator b idle timer expired
	//     bit 2 oscillator b active timer expired
	//     bit 1 oscillator a idle timer expired
	//     bit 0 oscillator a active timer expired
	//   0x13 alarm and line pending, write one to clear, reset 0x00
	//     bit 7..2 power alarms six down to one
	//     bit 1 hook change, either direction
	//     bit 0 ring trip
	//   0x15 timer enables, one per timer flag, reset 0x00
	//   0x16 alarm and line enables, one per flag, reset 0x00
	// a force bit at zero hands its circuit to automatic control
	// a power bit only counts while its select bit is set
	// in the variant without battery converter bit 4 of 0x0e
	// reads one whatever was written, and the output stays off
	// pending flags ignore a zero written to them, so software
	// may clear one flag without knowing the state of the others
	// unmapped addresses read zero and ignore writes

	////////////////////////////////////////////////////////////////
	// address decode, shared by the write and clear paths
	wire hit_power_override = (addr_i == `PWI_ADDR_POWER_OVERRIDE);
	wire hit_converter_power = (addr_i == `PWI_ADDR_CONVERTER_POWER);
	wire hit_timer_pending = (addr_i == `PWI_ADDR_TIMER_PENDING);
	wire hit_alarm_pending = (addr_i == `PWI_ADDR_ALARM_PENDING);
	wire hit_timer_enable = (addr_i == `PWI_ADDR_TIMER_ENABLE);
	wire hit_alarm_enable = (addr_i == `PWI_ADDR_ALARM_ENABLE);

	// write strobes per register; one strobe reaches one register
	wire wr_power_override = wr_i & hit_power_override;
	wire wr_converter_power = wr_i & hit_converter_power;
	wire wr_timer_pending = wr_i & hit_timer_pending;
	wire wr_alarm_pending = wr_i & hit_alarm_pending;
	wire wr_timer_enable = wr_i & hit_timer_enable;
	wire wr_alarm_enable = wr_i & hit_alarm_enable;

	// flag names of the timer pending register, msb first
	wire meter_idle_timer_pending = timer_irq_pending[7];
	wire meter_active_timer_pending = timer_irq_pending[6];
	wire ring_idle_timer_pending = timer_irq_pending[5];
	wire ring_active_timer_pending = timer_irq_pending[4];
	wire osc_b_idle_timer_pending = timer_irq_pending[3];
	wire osc_b_active_timer_pending = timer_irq_pending[2];
	wire osc_a_idle_timer_pending = timer_irq_pending[1];
	wire osc_a_active_timer_pending = timer_irq_pending[0];

	// flag names of the alarm and line pending register, msb first
	wire power_alarm_6_pending = alarm_line_irq_pending[7];
	wire power_alarm_5_pending = alarm_line_irq_pending[6];
	wire power_alarm_4_pending = alarm_line_irq_pending[5];
	wire power_alarm_3_pending = alarm_line_irq_pending[4];
	wire power_alarm_2_pending = alarm_line_irq_pending[3];
	wire power_alarm_1_pending = alarm_line_irq_pending[2];
	wire hook_change_pending = alarm_line_irq_pending[1];
	wire ring_trip_pending = alarm_line_irq_pending[0];

	// converter select and power fields
	wire adc_manual_select = converter_power_ctrl[`PWI_BIT_ADC_SEL];
	wire adc_manual_power = converter_power_ctrl[`PWI_BIT_ADC_PWR];
	wire dac_manual_select = converter_power_ctrl[`PWI_BIT_DAC_SEL];
	wire dac_manual_power = converter_power_ctrl[`PWI_BIT_DAC_PWR];
	wire transamp_manual_select = converter_power_ctrl[`PWI_BIT_GM_SEL];
	wire transamp_manual_power = converter_power_ctrl[`PWI_BIT_GM_PWR];

	////////////////////////////////////////////////////////////////
	// synchronise event sources, pins are outside the clock domain
	pwi_sync u_timer_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.async_i(timer_evt_i),
		.sync_o(timer_sync)
	);

	pwi_sync u_alarm_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.async_i({power_alarm_i, hook_i, ring_trip_i}),
		.sync_o(alarm_sync)
	);

	// previous synchronised values for edge detection
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			timer_prev <= 8'h00;
			alarm_prev <= 8'h00;
			hook_prev <= 1'b0;
			alarm_prev_valid <= 1'b0;
		end else begin
			timer_prev <= timer_sync;
			alarm_prev <= alarm_sync;
			hook_prev <= alarm_sync[1];
			alarm_prev_valid <= 1'b1;
		end
	end

	// event wiring into the pending flags
	//   timer_evt_i[7..0] feed timer pending bits 7..0 one to one
	//   power_alarm_i[5..0] feed alarm pending bits 7..2
	//   hook_i feeds bit 1 on both edges, off-hook and on-hook
	//   ring_trip_i feeds bit 0 on its rising edge
	// a held level sets its flag once; software clears it and the
	// flag stays clear until the level drops and rises again, or for hook_i until it changes
	// a pulse shorter than one clock may slip past the synchroniser,
	// so sources must hold an event for at least one clock period
	// the pending flip-flop costs one more clock on top of the two stages

	// rising edges set the timer flags
	assign timer_evt = timer_sync & ~timer_prev;
	// alarms and ring trip on rising edge; hook on either edge
	assign alarm_evt[7:2] = alarm_sync[7:2] & ~alarm_prev[7:2];
	assign alarm_evt[1] = alarm_prev_valid & (alarm_sync[1] ^ hook_prev);
	assign alarm_evt[0] = alarm_sync[0] & ~alarm_prev[0];

	////////////////////////////////////////////////////////////////
	// write-one-to-clear decode; a zero bit leaves the flag alone
	assign timer_clr = wr_timer_pending ? wdata_i : 8'h00;
	assign alarm_clr = wr_alarm_pending ? wdata_i : 8'h00;

	pwi_pending u_timer_pending (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.event_i(timer_evt),
		.clear_i(timer_clr),
		.pending_o(timer_irq_pending)
	);

	pwi_pending u_alarm_pending (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.event_i(alarm_evt),
		.clear_i(alarm_clr),
		.pending_o(alarm_line_irq_pending)
	);

	////////////////////////////////////////////////////////////////
	// override register; reserved bits never store
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			power_override_ctrl <= `PWI_RST_POWER_OVERRIDE;
		else if (wr_power_override)
			power_override_ctrl <= wdata_i & `PWI_MASK_POWER_OVERRIDE;
	end

	// converter register; reserved bits never store
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			converter_power_ctrl <= `PWI_RST_CONVERTER_POWER;
		else if (wr_converter_power)
			converter_power_ctrl <= wdata_i & `PWI_MASK_CONVERTER_POWER;
	end

	// timer enables, one per pending flag
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			timer_irq_enable <= `PWI_RST_ENABLE;
		else if (wr_timer_enable)
			timer_irq_enable <= wdata_i;
	end

	// alarm and line enables, one per pending flag
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			alarm_irq_enable <= `PWI_RST_ENABLE;
		else if (wr_alarm_enable)
			alarm_irq_enable <= wdata_i;
	end

	// converter-off bit stuck at one in the variant without converter
	assign battery_conv_force_off = (HAS_BATT_CONV == 0) ? 1'b1 :
		power_override_ctrl[`PWI_BIT_BATT_OFF];
	assign meter_dac_force_on = power_override_ctrl[`PWI_BIT_METER_ON];
	assign monitor_conv_force_off = power_override_ctrl[`PWI_BIT_MON_OFF];
	assign line_bias_force_off = power_override_ctrl[`PWI_BIT_BIAS_OFF];
	assign line_iface_force_off = power_override_ctrl[`PWI_BIT_IFACE_OFF];
	assign po_read = {2'b00, meter_dac_force_on, battery_conv_force_off, monitor_conv_force_off,
		1'b0, line_bias_force_off, line_iface_force_off};

	////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses return zero
	always @* begin
		case (addr_i)
			`PWI_ADDR_POWER_OVERRIDE: next_rdata = po_read;
			`PWI_ADDR_CONVERTER_POWER: next_rdata = converter_power_ctrl;
			`PWI_ADDR_TIMER_PENDING: next_rdata = {meter_idle_timer_pending, meter_active_timer_pending,
				ring_idle_timer_pending, ring_active_timer_pending, osc_b_idle_timer_pending,
				osc_b_active_timer_pending, osc_a_idle_timer_pending, osc_a_active_timer_pending};
			`PWI_ADDR_ALARM_PENDING: next_rdata = {power_alarm_6_pending, power_alarm_5_pending,
				power_alarm_4_pending, power_alarm_3_pending, power_alarm_2_pending, power_alarm_1_pending,
				hook_change_pending, ring_trip_pending};
			`PWI_ADDR_TIMER_ENABLE: next_rdata = timer_irq_enable;
			`PWI_ADDR_ALARM_ENABLE: next_rdata = alarm_irq_enable;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always @(posedge mclk_i) begin
		if (!rst_b_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// all outputs come from flip-flops, so each follows its register
	// one clock after the write; the analog side sees no glitches
	// while the register bank decodes a new bus cycle

	// force outputs of the override register
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			meter_dac_on_o <= 1'b0;
			battery_conv_off_o <= 1'b0;
			monitor_conv_off_o <= 1'b0;
			line_bias_off_o <= 1'b0;
			line_iface_off_o <= 1'b0;
		end else begin
			meter_dac_on_o <= meter_dac_force_on;
			battery_conv_off_o <= battery_conv_force_off;
			monitor_conv_off_o <= monitor_conv_force_off;
			line_bias_off_o <= line_bias_force_off;
			line_iface_off_o <= line_iface_force_off;
		end
	end

	// converter outputs; a power bit without its select means automatic
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			adc_manual_o <= 1'b0;
			adc_on_o <= 1'b0;
			dac_manual_o <= 1'b0;
			dac_on_o <= 1'b0;
			transamp_manual_o <= 1'b0;
			transamp_on_o <= 1'b0;
		end else begin
			adc_manual_o <= adc_manual_select;
			adc_on_o <= adc_manual_select & adc_manual_power;
			dac_manual_o <= dac_manual_select;
			dac_on_o <= dac_manual_select & dac_manual_power;
			transamp_manual_o <= transamp_manual_select;
			transamp_on_o <= transamp_manual_select & transamp_manual_power;
		end
	end

	// masked pending summaries; a zero enable bit hides its flag
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			timer_irq_o <= 8'h00;
			alarm_irq_o <= 8'h00;
		end else begin
			timer_irq_o <= timer_irq_pending & timer_irq_enable;
			alarm_irq_o <= alarm_line_irq_pending & alarm_irq_enable;
		end
	end
endmodule // pwi_power_irq

// *** rtl/pwi_sync.v ***
`timescale 1ns/1ps
// two-stage synchroniser for a bus of asynchronous levels
module pwi_sync (
	// clock and reset
	input wire mclk_i,
	input wire rst_b_i,
	// levels
	input wire [7:0] async_i,
	output reg [7:0] sync_o
);
	reg [7:0] meta;

	// first stage feeds only the second
	always @(posedge mclk_i) begin
		if (!rst_b_i) begin
			meta <= 8'h00;
			sync_o <= 8'h00;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule // pwi_sync

// *** verif/pwi_monitor.sv ***
`timescale 1ns/1ps
module pwi_monitor #(
	parameter HAS_BATT_CONV = 1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// power controls
	input wire logic meter_dac_on_o,
	input wire logic battery_conv_off_o,
	input wire logic line_iface_off_o,
	input wire logic adc_on_o,
	input wire logic dac_on_o,
	input wire logic transamp_on_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// a write lands at its edge, so the output follows one edge later
	sequence s_wr(logic [7:0] a);
		wr_i && addr_i == a;
	endsequence
	a_meter_force_on: assert property (s_wr(8'h0e) ##0 wdata_i[5] |-> ##2 meter_dac_on_o) else $error("meter off");
	a_batt_follow_auto: assert property (
		s_wr(8'h0e) ##0 (HAS_BATT_CONV == 1 && !wdata_i[4]) |-> ##2 !battery_conv_off_o) else $error("battery forced");
	a_batt_stuck_off: assert property (s_wr(8'h0e) ##0 HAS_BATT_CONV == 0 |-> ##2 battery_conv_off_o)
		else $error("battery not stuck off");
	a_iface_force_off: assert property (s_wr(8'h0e) ##0 wdata_i[0] |-> ##2 line_iface_off_o) else $error("iface on");
	a_adc_manual_on: assert property (s_wr(8'h0f) ##0 wdata_i[5:4] == 2'b11 |-> ##2 adc_on_o) else $error("adc off");
	a_adc_auto_off: assert property (s_wr(8'h0f) ##0 !wdata_i[5] |-> ##2 !adc_on_o) else $error("adc manual");
	a_dac_manual_on: assert property (s_wr(8'h0f) ##0 wdata_i[3:2] == 2'b11 |-> ##2 dac_on_o) else $error("dac off");
	a_gm_auto_off: assert property (s_wr(8'h0f) ##0 !wdata_i[1] |-> ##2 !transamp_on_o) else $error("gm manual");
	a_rsvd_read_zero: assert property (rd_i && addr_i == 8'h0e |=> (rdata_o & 8'hc4) == 8'h00)
		else $error("reserved set");
	a_unmapped_zero: assert property (rd_i && addr_i == 8'h20 |=> rdata_o == 8'h00) else $error("unmapped data");
	a_idle_rdata_zero: assert property (!rd_i |=> rdata_o == 8'h00) else $error("stale read data");
endmodule // pwi_monitor
bind pwi_power_irq pwi_monitor #(.HAS_BATT_CONV(HAS_BATT_CONV)) pwi_monitor_inst (.*);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
	logic mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, hook_i = 0, ring_trip_i = 0;
	logic [7:0] addr_i = 0, wdata_i = 0, timer_evt_i = 0, rdata_o, timer_irq_o, alarm_irq_o;
	logic [5:0] power_alarm_i = 0;
	logic meter_dac_on_o, battery_conv_off_o, monitor_conv_off_o, line_bias_off_o, line_iface_off_o;
	logic adc_manual_o, adc_on_o, dac_manual_o, dac_on_o, transamp_manual_o, transamp_on_o;
	logic [7:0] d, nb_rdata;
	logic nb_batt;
	int err_total = 0, n_tests = 0, cyc = 0;
	pwi_power_irq pwi_power_irq_inst (.*);
	// second copy as the variant without battery converter, sharing the bus
	if (1) begin : nb
		pwi_power_irq #(.HAS_BATT_CONV(0)) pwi_power_irq_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
			.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(nb_rdata), .timer_evt_i(timer_evt_i),
			.power_alarm_i(power_alarm_i), .hook_i(hook_i), .ring_trip_i(ring_trip_i), .meter_dac_on_o(),
			.battery_conv_off_o(nb_batt), .monitor_conv_off_o(), .line_bias_off_o(), .line_iface_off_o(),
			.adc_manual_o(), .adc_on_o(), .dac_manual_o(), .dac_on_o(), .transamp_manual_o(), .transamp_on_o(),
			.timer_irq_o(), .alarm_irq_o());
	end
	////////////////////////////////////////////////////////////
	// bus tasks; each waits an edge first so strobes never toggle twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		`CHK(n, e, rdata_o)
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic final_report;
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	// hang guard, well above the ~400 cycles the run needs
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(8'h0e, 8'h10, "ovr rst");
		rd(8'h0f, 8'h00, "cnv rst");
		rd(8'h12, 8'h00, "tmr rst");
		rd(8'h13, 8'h00, "alm rst");
		`CHK("batt rst", 1'b1, battery_conv_off_o)
		`CHK("nb batt", 1'b1, nb_batt)
		// one bit at a time, reserved ones included
		for (int i = 0; i < 8; i++) begin
			d = 8'h01 << i;
			wr(8'h0e, d);
			rd(8'h0e, d & 8'h3b, "ovr rd");
			`CHK("nb ovr rd", (d & 8'h3b) | 8'h10, nb_rdata)
			`CHK("nb batt", 1'b1, nb_batt)
			`CHK("ovr outs", {d[5], d[4], d[3], d[1], d[0]}, {meter_dac_on_o, battery_conv_off_o, monitor_conv_off_o, line_bias_off_o, line_iface_off_o})
		end
		// every select/power pair, so power without select must stay automatic
		for (int i = 0; i < 64; i++) begin
			d = i[7:0];
			wr(8'h0f, d);
			rd(8'h0f, d, "cnv rd");
			`CHK("cnv sel", {d[5], d[3], d[1]}, {adc_manual_o, dac_manual_o, transamp_manual_o})
			`CHK("cnv on", {d[5] & d[4], d[3] & d[2], d[1] & d[0]}, {adc_on_o, dac_on_o, transamp_on_o})
		end
		wr(8'h0f, 8'hff);
		rd(8'h0f, 8'h3f, "cnv rsvd");
		// timer flags: sticky, write-one-to-clear, masked by enables
		timer_evt_i <= 8'ha5;
		tk(5);
		rd(8'h12, 8'ha5, "tmr set");
		wr(8'h12, 8'h00);
		rd(8'h12, 8'ha5, "tmr keep");
		wr(8'h12, 8'h05);
		rd(8'h12, 8'ha0, "tmr clr");
		wr(8'h15, 8'hff);
		tk(2);
		`CHK("tmr irq", 8'ha0, timer_irq_o)
		wr(8'h15, 8'h80);
		tk(2);
		`CHK("tmr mask", 8'h80, timer_irq_o)
		// a new event meets a clear of the same bit in one cycle
		timer_evt_i <= 8'h00;
		tk(4);
		@(posedge mclk_i);
		timer_evt_i <= 8'h01;
		@(posedge mclk_i);
		wr(8'h12, 8'h01);
		rd(8'h12, 8'ha1, "set wins");
		// alarms, hook change both ways, ring trip
		power_alarm_i <= 6'h3f;
		ring_trip_i <= 1'b1;
		hook_i <= 1'b1;
		tk(5);
		rd(8'h13, 8'hff, "alm set");
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h00, "alm clr");
		hook_i <= 1'b0;
		tk(5);
		rd(8'h13, 8'h02, "on hook");
		wr(8'h16, 8'h02);
		tk(2);
		`CHK("alm irq", 8'h02, alarm_irq_o)
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00, "unmapped");
		rd(8'h0e, 8'h00, "ovr after");
		final_report;
	end
endmodule // tb_top
